// file: amag_pkg.sv
// Address map, register layout and reset values of the address map access guard
package amag_pkg;
  typedef enum logic [3:0] {
    RG_NONE, RG_EXT, RG_XBUS, RG_EXTIO, RG_DATA_SRAM, RG_XSFR, RG_EXTENDED_FUNCTION_REGISTER_AREA,
    RG_DUAL_PORT_RAM, RG_SFR, RG_FLASH, RG_PROGRAM_SRAM, RG_EPSRAM, RG_IMB
  } amag_region_type;

  // Segment and page layout
  localparam int SEG_LSB = 16;
  localparam int PAGE_LSB = 14;
  localparam logic [7:0] SEG_SYS = 8'h00;

  // Address areas
  localparam logic [23:0] EXT0_END = 24'h007FFF;
  localparam logic [23:0] DATA_SRAM_BASE = 24'h00D800;
  localparam logic [23:0] DATA_SRAM_END = 24'h00DFFF;
  localparam logic [23:0] XSFR_BASE = 24'h00E000;
  localparam logic [23:0] XSFR_END = 24'h00EFFF;
  localparam logic [23:0] EXTENDED_FUNCTION_REGISTER_AREA_BASE = 24'h00F000;
  localparam logic [23:0] EXTENDED_FUNCTION_REGISTER_AREA_END = 24'h00F1FF;
  localparam logic [23:0] DUAL_PORT_RAM_BASE = 24'h00F600;
  localparam logic [23:0] DUAL_PORT_RAM_BIT_BASE = 24'h00FD00;
  localparam logic [23:0] DUAL_PORT_RAM_END = 24'h00FDFF;
  localparam logic [23:0] SFR_BASE = 24'h00FE00;
  localparam logic [23:0] SFR_END = 24'h00FFFF;
  localparam logic [23:0] EXT1_BASE = 24'h010000;
  localparam logic [23:0] EXT1_END = 24'h1FFFFF;
  localparam logic [23:0] XBUS0_BASE = 24'h204000;
  localparam logic [23:0] XBUS0_END = 24'h2047FF;
  localparam logic [23:0] XBUS1_BASE = 24'h20B000;
  localparam logic [23:0] XBUS1_END = 24'h20B3FF;
  localparam logic [23:0] EXTIO_BASE = 24'h210000;
  localparam logic [23:0] EXTIO_END = 24'h3FFFFF;
  localparam logic [23:0] EXT2_BASE = 24'h400000;
  localparam logic [23:0] EXT2_END = 24'hBFFFFF;
  localparam logic [23:0] FLASH_BASE = 24'hC00000;
  localparam logic [23:0] FLASH_END = 24'hC10FFF;
  localparam logic [23:0] FLASH_RSV_BASE = 24'hC0F000;
  localparam logic [23:0] FLASH_RSV_END = 24'hC0FFFF;
  localparam logic [23:0] PROGRAM_SRAM_BASE = 24'hE00000;
  localparam logic [23:0] PROGRAM_SRAM_END = 24'hE00FFF;
  localparam logic [23:0] EPSRAM_BASE = 24'hE80000;
  localparam logic [23:0] EPSRAM_END = 24'hE80FFF;
  localparam logic [23:0] IMB_BASE = 24'hFFFF00;

  // Flash organisation
  localparam int FLASH_SECTORS = 17;
  localparam int SECTOR_LSB = 12;
  localparam int PROG_BLK_LSB = 7;

  // Memory code word
  localparam int CODE_W = 21;
  localparam int DATA_W = 16;

  // Protection checker
  localparam int NLEVEL = 4;
  localparam logic [2:0] NEED_R = 3'h1;
  localparam logic [2:0] NEED_W = 3'h2;
  localparam logic [2:0] NEED_X = 3'h4;

  // Register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_CP = 8'h08;
  localparam logic [7:0] OFS_STKUL = 8'h0C;
  localparam logic [7:0] OFS_STKLL = 8'h10;
  localparam logic [7:0] OFS_PSWP = 8'h14;
  localparam logic [7:0] OFS_FLWP = 8'h18;
  localparam logic [7:0] OFS_KEY = 8'h1C;
  localparam logic [7:0] OFS_UNLOCK = 8'h20;
  localparam int OFS_PROT = 8'h40;
  localparam int PROT_STRIDE = 8'h10;

  // Control and status bit positions
  localparam int CTL_PROT_EN = 0;
  localparam int CTL_PAR_EN = 1;
  localparam int CTL_ECC_EN = 2;
  localparam int CTL_PSWP_EN = 3;
  localparam int CTL_RDPROT = 4;
  localparam int CTL_RELOCK = 5;
  localparam int ST_UNLOCKED = 6;

  // Reset values
  localparam logic [4:0] CTL_RST = 5'h00;
  localparam logic [15:0] CP_RST = 16'hF600;
  localparam logic [15:0] STKUL_RST = 16'hF600;
  localparam logic [15:0] STKLL_RST = 16'hFDFE;
  localparam logic [15:0] KEY_RST = 16'h0000;
endpackage

// file: amag_range_check.sv
// One protection range: address window and permission check
`timescale 1ns/1ps
module amag_range_check #(
  parameter int AW = 24
) (
  // Access under test
  input logic en,
  input logic [AW-1:0] addr,
  input logic [2:0] need,
  // Range settings
  input logic [AW-1:0] lo,
  input logic [AW-1:0] hi,
  input logic [2:0] perm,
  // Verdict
  output logic allow
);
  if (AW < 1) begin : g_bad
    $error("AW must be positive");
  end

  assign allow = en && addr >= lo && addr <= hi && |(perm & need);
endmodule

// file: amag_guard.sv
// Access guard: address decode, access checks, memory read check and AHB-Lite registers
//
// Our own choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
module amag_guard #(
  parameter bit HAS_EXT_BUS = 1'b1,
  parameter int NRANGE = 2
) (
  // Clock and reset
  input logic hclk,
  input logic hresetn,
  // AHB-Lite register slave
  input logic hsel,
  input logic [31:0] haddr,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic [2:0] hsize,
  input logic [31:0] hwdata,
  input logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Access request from fetch_manager or data_manager
  input logic acc_valid,
  input logic [23:0] acc_addr,
  input logic acc_write,
  input logic acc_fetch,
  input logic acc_byte,
  input logic acc_bit,
  input logic acc_stack,
  input logic acc_gpr,
  input logic [3:0] acc_gpr_idx,
  input logic [1:0] acc_level,
  // Checked access
  output logic res_valid,
  output logic [23:0] res_addr,
  output logic [1:0] res_byte_en,
  output amag_pkg::amag_region_type res_region,
  output logic [9:0] res_page,
  output logic [9:0] res_flash_block,
  output logic res_grant,
  output logic res_external,
  output logic trap_prot,
  output logic trap_stack_over,
  output logic trap_stack_under,
  // Memory read check
  input logic mem_rvalid,
  input logic [20:0] mem_rcode,
  output logic rd_valid,
  output logic [15:0] rd_data,
  output logic rd_error,
  output logic rd_corrected
);
  localparam int NE = amag_pkg::NLEVEL * NRANGE;

  if (NRANGE < 1 || NRANGE > 3) begin : g_bad
    $error("NRANGE must be 1 to 3");
  end

  function automatic logic [4:0] syndrome(input logic [20:0] c);
    logic [4:0] s;
    s = 5'h00;
    for (int i = 0; i < amag_pkg::CODE_W; i++) begin
      if (c[i]) s = s ^ 5'(i + 1);
    end
    return s;
  endfunction

  function automatic logic [15:0] data_of(input logic [20:0] c);
    logic [15:0] d;
    int k;
    d = 16'h0000;
    k = 0;
    for (int i = 0; i < amag_pkg::CODE_W; i++) begin
      if (((i + 1) & i) != 0) begin
        d[k[3:0]] = c[i];
        k++;
      end
    end
    return d;
  endfunction

  function automatic amag_pkg::amag_region_type region_of(input logic [23:0] x);
    amag_pkg::amag_region_type r;
    r = HAS_EXT_BUS ? amag_pkg::RG_EXT : amag_pkg::RG_NONE;
    if (x[23:amag_pkg::SEG_LSB] == amag_pkg::SEG_SYS) begin
      if (x <= amag_pkg::EXT0_END) r = amag_pkg::RG_EXT;
      else if (x inside {[amag_pkg::DATA_SRAM_BASE:amag_pkg::DATA_SRAM_END]}) r = amag_pkg::RG_DATA_SRAM;
      else if (x inside {[amag_pkg::XSFR_BASE:amag_pkg::XSFR_END]}) r = amag_pkg::RG_XSFR;
      else if (x inside {[amag_pkg::EXTENDED_FUNCTION_REGISTER_AREA_BASE:amag_pkg::EXTENDED_FUNCTION_REGISTER_AREA_END]}) r = amag_pkg::RG_EXTENDED_FUNCTION_REGISTER_AREA;
      else if (x inside {[amag_pkg::DUAL_PORT_RAM_BASE:amag_pkg::DUAL_PORT_RAM_END]}) r = amag_pkg::RG_DUAL_PORT_RAM;
      else if (x inside {[amag_pkg::SFR_BASE:amag_pkg::SFR_END]}) r = amag_pkg::RG_SFR;
    end
    else if (x inside {[amag_pkg::EXT1_BASE:amag_pkg::EXT1_END]}) r = amag_pkg::RG_EXT;
    else if (x inside {[amag_pkg::XBUS0_BASE:amag_pkg::XBUS0_END]}) r = amag_pkg::RG_XBUS;
    else if (x inside {[amag_pkg::XBUS1_BASE:amag_pkg::XBUS1_END]}) r = amag_pkg::RG_XBUS;
    else if (x inside {[amag_pkg::EXTIO_BASE:amag_pkg::EXTIO_END]}) r = amag_pkg::RG_EXTIO;
    else if (x inside {[amag_pkg::EXT2_BASE:amag_pkg::EXT2_END]}) r = amag_pkg::RG_EXT;
    else if (x inside {[amag_pkg::FLASH_BASE:amag_pkg::FLASH_END]}) r = amag_pkg::RG_FLASH;
    else if (x inside {[amag_pkg::PROGRAM_SRAM_BASE:amag_pkg::PROGRAM_SRAM_END]}) r = amag_pkg::RG_PROGRAM_SRAM;
    else if (x inside {[amag_pkg::EPSRAM_BASE:amag_pkg::EPSRAM_END]}) r = amag_pkg::RG_EPSRAM;
    else if (x >= amag_pkg::IMB_BASE) r = amag_pkg::RG_IMB;
    return r;
  endfunction

  // Software visible state
  logic [4:0] ctl, next_ctl;
  logic [5:0] stat, next_stat;
  logic [15:0] cp, next_cp, stkul, next_stkul, stkll, next_stkll, key, next_key;
  logic [12:0] pswp, next_pswp;
  logic [16:0] flwp, next_flwp;
  logic unlocked, next_unlocked;
  logic [23:0] lo [NE];
  logic [23:0] next_lo [NE];
  logic [23:0] hi [NE];
  logic [23:0] next_hi [NE];
  logic [2:0] perm [NE];
  logic [2:0] next_perm [NE];
  logic wr_pend, next_wr_pend;
  logic [7:0] wr_ofs, next_wr_ofs;
  logic [31:0] next_hrdata;

  // Access check
  logic [23:0] a, foff;
  logic [15:0] gpr_word;
  amag_pkg::amag_region_type rg;
  logic [4:0] sec;
  logic [2:0] need;
  logic [NE-1:0] allow;
  logic in_rsv, bit_ok, wp_hit, rd_blk, ps_hit, ov, un, prot_bad, grant;

  // Memory check
  logic [4:0] syn;
  logic [20:0] fixed;
  logic next_rd_valid, next_rd_error, next_rd_corr;
  logic [15:0] next_rd_data;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign gpr_word = cp + {11'h000, acc_gpr_idx, 1'b0};

  always_comb begin
    a = acc_addr;
    if (acc_gpr) a = {8'h00, acc_byte ? cp + {12'h000, acc_gpr_idx} : gpr_word};
    if (!acc_byte) a[0] = 1'b0;
    rg = region_of(a);
    foff = a - amag_pkg::FLASH_BASE;
    sec = foff[amag_pkg::SECTOR_LSB +: 5];
    need = acc_fetch ? amag_pkg::NEED_X : (acc_write ? amag_pkg::NEED_W : amag_pkg::NEED_R);
    in_rsv = a inside {[amag_pkg::FLASH_RSV_BASE:amag_pkg::FLASH_RSV_END]};
    bit_ok = !acc_bit || acc_gpr || rg == amag_pkg::RG_SFR || rg == amag_pkg::RG_EXTENDED_FUNCTION_REGISTER_AREA
      || (rg == amag_pkg::RG_DUAL_PORT_RAM && a >= amag_pkg::DUAL_PORT_RAM_BIT_BASE);
    wp_hit = rg == amag_pkg::RG_FLASH && acc_write && flwp[sec] && !unlocked;
    rd_blk = rg == amag_pkg::RG_FLASH && !acc_write && !acc_fetch && ctl[amag_pkg::CTL_RDPROT]
      && !unlocked;
    ps_hit = rg == amag_pkg::RG_PROGRAM_SRAM && acc_write && ctl[amag_pkg::CTL_PSWP_EN]
      && {1'b0, a[11:0]} < pswp;
    ov = acc_stack && acc_write && a[15:0] < stkul;
    un = acc_stack && !acc_write && a[15:0] > stkll;
    prot_bad = ctl[amag_pkg::CTL_PROT_EN] && allow == '0;
    grant = rg != amag_pkg::RG_NONE && bit_ok && !in_rsv && !wp_hit && !rd_blk && !ps_hit
      && !ov && !un && !prot_bad;
  end

  for (genvar e = 0; e < NE; e++) begin : g_range
    amag_range_check #(.AW(24)) u_range (
      .en(acc_level == 2'(e / NRANGE)),
      .addr(a),
      .need(need),
      .lo(lo[e]),
      .hi(hi[e]),
      .perm(perm[e]),
      .allow(allow[e])
    );
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res_valid <= 1'b0;
      res_addr <= 24'h000000;
      res_byte_en <= 2'h0;
      res_region <= amag_pkg::RG_NONE;
      res_page <= 10'h000;
      res_flash_block <= 10'h000;
      res_grant <= 1'b0;
      res_external <= 1'b0;
      trap_prot <= 1'b0;
      trap_stack_over <= 1'b0;
      trap_stack_under <= 1'b0;
    end else begin
      res_valid <= acc_valid;
      res_addr <= a;
      res_byte_en <= acc_byte ? (a[0] ? 2'h2 : 2'h1) : 2'h3;
      res_region <= rg;
      res_page <= a[23:amag_pkg::PAGE_LSB];
      res_flash_block <= foff[amag_pkg::PROG_BLK_LSB +: 10];
      res_grant <= acc_valid && grant;
      res_external <= acc_valid && grant && (rg == amag_pkg::RG_EXT || rg == amag_pkg::RG_EXTIO);
      trap_prot <= acc_valid && prot_bad;
      trap_stack_over <= acc_valid && ov;
      trap_stack_under <= acc_valid && un;
    end
  end

  always_comb begin
    syn = syndrome(mem_rcode);
    fixed = mem_rcode;
    next_rd_error = 1'b0;
    next_rd_corr = 1'b0;
    if (mem_rvalid && ctl[amag_pkg::CTL_ECC_EN]) begin
      if (syn != 5'h00 && syn <= 5'(amag_pkg::CODE_W)) begin
        fixed = mem_rcode ^ (21'h000001 << (syn - 5'h01));
        next_rd_corr = 1'b1;
      end
      next_rd_error = syn > 5'(amag_pkg::CODE_W);
    end
    else if (mem_rvalid && ctl[amag_pkg::CTL_PAR_EN]) begin
      next_rd_error = ^{data_of(mem_rcode), mem_rcode[0]};
    end
    next_rd_valid = mem_rvalid && !next_rd_error;
    next_rd_data = next_rd_error ? 16'h0000 : data_of(fixed);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_valid <= 1'b0;
      rd_data <= 16'h0000;
      rd_error <= 1'b0;
      rd_corrected <= 1'b0;
    end else begin
      rd_valid <= next_rd_valid;
      rd_data <= next_rd_data;
      rd_error <= next_rd_error;
      rd_corrected <= next_rd_corr;
    end
  end

  // Register read data is captured in the address phase
  always_comb begin
    next_hrdata = hrdata;
    if (hsel && htrans[1] && hready && !hwrite) begin
      next_hrdata = 32'h00000000;
      case (haddr[7:0])
        amag_pkg::OFS_CTRL: next_hrdata = {27'h0000000, ctl};
        amag_pkg::OFS_STAT: next_hrdata = {25'h0000000, unlocked, stat};
        amag_pkg::OFS_CP: next_hrdata = {16'h0000, cp};
        amag_pkg::OFS_STKUL: next_hrdata = {16'h0000, stkul};
        amag_pkg::OFS_STKLL: next_hrdata = {16'h0000, stkll};
        amag_pkg::OFS_PSWP: next_hrdata = {19'h00000, pswp};
        amag_pkg::OFS_FLWP: next_hrdata = {15'h0000, flwp};
        default: begin
          for (int e = 0; e < NE; e++) begin
            if (haddr[7:0] == 8'(amag_pkg::OFS_PROT + e * amag_pkg::PROT_STRIDE)) next_hrdata = {8'h00, lo[e]};
            if (haddr[7:0] == 8'(amag_pkg::OFS_PROT + e * amag_pkg::PROT_STRIDE + 4)) next_hrdata = {8'h00, hi[e]};
            if (haddr[7:0] == 8'(amag_pkg::OFS_PROT + e * amag_pkg::PROT_STRIDE + 8)) next_hrdata = {29'h0, perm[e]};
          end
        end
      endcase
    end
  end

  always_comb begin
    next_wr_pend = hsel && htrans[1] && hready && hwrite;
    next_wr_ofs = next_wr_pend ? haddr[7:0] : wr_ofs;
    next_ctl = ctl;
    next_cp = cp;
    next_stkul = stkul;
    next_stkll = stkll;
    next_pswp = pswp;
    next_flwp = flwp;
    next_key = key;
    next_unlocked = unlocked;
    next_lo = lo;
    next_hi = hi;
    next_perm = perm;
    next_stat = stat;
    if (wr_pend) begin
      case (wr_ofs)
        amag_pkg::OFS_CTRL: begin
          next_ctl = hwdata[4:0];
          if (hwdata[amag_pkg::CTL_RELOCK]) next_unlocked = 1'b0;
        end
        amag_pkg::OFS_STAT: next_stat = stat & ~hwdata[5:0];
        amag_pkg::OFS_CP: next_cp = {hwdata[15:1], 1'b0};
        amag_pkg::OFS_STKUL: next_stkul = hwdata[15:0];
        amag_pkg::OFS_STKLL: next_stkll = hwdata[15:0];
        amag_pkg::OFS_PSWP: next_pswp = hwdata[12:0];
        amag_pkg::OFS_FLWP: next_flwp = hwdata[16:0];
        amag_pkg::OFS_KEY: begin
          if (unlocked || !ctl[amag_pkg::CTL_RDPROT]) next_key = hwdata[15:0];
        end
        amag_pkg::OFS_UNLOCK: next_unlocked = hwdata[15:0] == key;
        default: begin
          for (int e = 0; e < NE; e++) begin
            if (wr_ofs == 8'(amag_pkg::OFS_PROT + e * amag_pkg::PROT_STRIDE)) next_lo[e] = hwdata[23:0];
            if (wr_ofs == 8'(amag_pkg::OFS_PROT + e * amag_pkg::PROT_STRIDE + 4)) next_hi[e] = hwdata[23:0];
            if (wr_ofs == 8'(amag_pkg::OFS_PROT + e * amag_pkg::PROT_STRIDE + 8)) next_perm[e] = hwdata[2:0];
          end
        end
      endcase
    end
    // Events set after the clear so that a same-cycle event survives
    next_stat = next_stat | {next_rd_corr, next_rd_error, acc_valid && in_rsv, acc_valid && un,
      acc_valid && ov, acc_valid && prot_bad};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
      ctl <= amag_pkg::CTL_RST;
      stat <= 6'h00;
      cp <= amag_pkg::CP_RST;
      stkul <= amag_pkg::STKUL_RST;
      stkll <= amag_pkg::STKLL_RST;
      pswp <= 13'h0000;
      flwp <= 17'h00000;
      key <= amag_pkg::KEY_RST;
      unlocked <= 1'b0;
      for (int e = 0; e < NE; e++) begin
        lo[e] <= 24'h000000;
        hi[e] <= 24'h000000;
        perm[e] <= 3'h0;
      end
    end else begin
      hrdata <= next_hrdata;
      wr_pend <= next_wr_pend;
      wr_ofs <= next_wr_ofs;
      ctl <= next_ctl;
      stat <= next_stat;
      cp <= next_cp;
      stkul <= next_stkul;
      stkll <= next_stkll;
      pswp <= next_pswp;
      flwp <= next_flwp;
      key <= next_key;
      unlocked <= next_unlocked;
      lo <= next_lo;
      hi <= next_hi;
      perm <= next_perm;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_trap_blocks;
    trap_prot |-> res_valid && !res_grant && !res_external;
  endproperty
  a_trap_blocks: assert property (p_trap_blocks) else $error("trap with granted access");
  property p_trap_cause;
    acc_valid && ctl[amag_pkg::CTL_PROT_EN] && allow == '0 |=> trap_prot;
  endproperty
  a_trap_cause: assert property (p_trap_cause) else $error("violation without trap");
  property p_stack_over;
    acc_valid && acc_stack && acc_write && !acc_gpr && acc_addr[15:0] < stkul |=> trap_stack_over ##1 stat[1];
  endproperty
  a_stack_over: assert property (p_stack_over) else $error("stack overrun missed");
  property p_rsv;
    res_valid && res_addr inside {[amag_pkg::FLASH_RSV_BASE:amag_pkg::FLASH_RSV_END]} |-> !res_grant;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flash sector granted");
  property p_seg0;
    res_valid && res_region inside {amag_pkg::RG_DATA_SRAM, amag_pkg::RG_DUAL_PORT_RAM, amag_pkg::RG_SFR,
      amag_pkg::RG_EXTENDED_FUNCTION_REGISTER_AREA} |-> res_addr[23:16] == amag_pkg::SEG_SYS;
  endproperty
  a_seg0: assert property (p_seg0) else $error("internal area outside segment 0");
  property p_gpr;
    acc_valid && acc_gpr && !acc_byte |=> res_addr == {8'h00, $past(gpr_word)};
  endproperty
  a_gpr: assert property (p_gpr) else $error("register bank address wrong");
  property p_ecc;
    mem_rvalid && ctl[amag_pkg::CTL_ECC_EN] && syndrome(mem_rcode) != 5'h00
      && syndrome(mem_rcode) <= 5'h15 |=> rd_valid && rd_corrected && !rd_error;
  endproperty
  a_ecc: assert property (p_ecc) else $error("single-bit error not corrected");
  property p_parity;
    mem_rvalid && !ctl[amag_pkg::CTL_ECC_EN] && ctl[amag_pkg::CTL_PAR_EN]
      && ^{data_of(mem_rcode), mem_rcode[0]} |=> rd_error && !rd_valid ##1 stat[4];
  endproperty
  a_parity: assert property (p_parity) else $error("parity error passed");
  property p_bit;
    res_valid && res_region == amag_pkg::RG_PROGRAM_SRAM && $past(acc_bit) |-> !res_grant;
  endproperty
  a_bit: assert property (p_bit) else $error("bit access granted outside bit areas");
  c_trap: cover property (trap_prot ##1 stat[0]);
  c_ext: cover property (res_external);
  c_corr: cover property (rd_corrected);
  c_under: cover property (trap_stack_under);
endmodule

// file: amag_cpu_model.sv
// Model of the fetch and data managers issuing accesses and memory read words
`timescale 1ns/1ps
module amag_cpu_model (
  // Clock
  input logic hclk,
  // Access request
  output logic acc_valid,
  output logic [23:0] acc_addr,
  output logic acc_write,
  output logic acc_fetch,
  output logic acc_byte,
  output logic acc_bit,
  output logic acc_stack,
  output logic acc_gpr,
  output logic [3:0] acc_gpr_idx,
  output logic [1:0] acc_level,
  // Memory read word
  output logic mem_rvalid,
  output logic [20:0] mem_rcode
);
  initial begin
    acc_valid = 1'b0;
    {acc_addr, acc_write, acc_fetch, acc_byte, acc_bit, acc_stack, acc_gpr, acc_gpr_idx, acc_level} = '0;
    mem_rvalid = 1'b0;
    mem_rcode = '0;
  end
  // One request for one cycle; the released address shows the inverse of the last value, other lines keep theirs
  task automatic req(input logic [23:0] a, input logic [5:0] k, input logic [3:0] x, input logic [1:0] l);
    @(posedge hclk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    {acc_gpr, acc_stack, acc_bit, acc_byte, acc_fetch, acc_write} <= k;
    acc_gpr_idx <= x;
    acc_level <= l;
    @(posedge hclk);
    acc_valid <= 1'b0;
    acc_addr <= ~a;
  endtask
  task automatic mem(input logic [20:0] c);
    @(posedge hclk);
    mem_rvalid <= 1'b1;
    mem_rcode <= c;
    @(posedge hclk);
    mem_rvalid <= 1'b0;
    mem_rcode <= ~c;
  endtask
endmodule

// file: tb_amag_guard.sv
// Self-checking testbench for the address map access guard
`timescale 1ns/1ps
module tb_amag_guard;
  localparam logic [5:0] RD = 6'h00, WR = 6'h01, FE = 6'h02, BY = 6'h04, BI = 6'h08, ST = 6'h10, GP = 6'h20;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, acc_level, res_byte_en;
  logic acc_valid, acc_write, acc_fetch, acc_byte, acc_bit, acc_stack, acc_gpr, mem_rvalid;
  logic [23:0] acc_addr, res_addr;
  logic [3:0] acc_gpr_idx;
  logic [20:0] mem_rcode;
  logic [15:0] rd_data;
  logic [9:0] res_page, res_flash_block;
  amag_pkg::amag_region_type res_region;
  logic res_valid, res_grant, res_external, trap_prot, trap_stack_over, trap_stack_under;
  logic rd_valid, rd_error, rd_corrected;
  int n_fail = 0;
  int n_checks = 0;
  amag_guard DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write), .acc_fetch(acc_fetch), .acc_byte(acc_byte),
    .acc_bit(acc_bit), .acc_stack(acc_stack), .acc_gpr(acc_gpr), .acc_gpr_idx(acc_gpr_idx), .acc_level(acc_level),
    .res_valid(res_valid), .res_addr(res_addr), .res_byte_en(res_byte_en), .res_region(res_region),
    .res_page(res_page), .res_flash_block(res_flash_block), .res_grant(res_grant), .res_external(res_external),
    .trap_prot(trap_prot), .trap_stack_over(trap_stack_over), .trap_stack_under(trap_stack_under),
    .mem_rvalid(mem_rvalid), .mem_rcode(mem_rcode), .rd_valid(rd_valid), .rd_data(rd_data), .rd_error(rd_error),
    .rd_corrected(rd_corrected));
  amag_cpu_model CPU (.hclk(hclk), .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_write(acc_write),
    .acc_fetch(acc_fetch), .acc_byte(acc_byte), .acc_bit(acc_bit), .acc_stack(acc_stack), .acc_gpr(acc_gpr),
    .acc_gpr_idx(acc_gpr_idx), .acc_level(acc_level), .mem_rvalid(mem_rvalid), .mem_rcode(mem_rcode));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask
  task automatic wait_rdy();
    for (int i = 0; i < 16; i++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) begin
        return;
      end
    end
    n_fail++;
    end_of_test();
  endtask
  // Single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    chk(n, e, r);
  endtask
  task automatic acc(input logic [23:0] a, input logic [5:0] k, input logic [1:0] l, input logic g);
    CPU.req(a, k, 4'h3, l);
    #1;
    chk("res_valid", 32'h1, {31'h0, res_valid});
    chk("res_grant", {31'h0, g}, {31'h0, res_grant});
  endtask
  task automatic t_regs();
    rdc("cp", 8'h08, 32'h0000F600);
    rdc("stkul", 8'h0C, 32'h0000F600);
    rdc("stkll", 8'h10, 32'h0000FDFE);
    wr(8'h3C, 32'h0);
    chk("hresp", 32'h0, {31'h0, hresp});
    rdc("unmapped", 8'h3C, 32'h0);
    $display("registers done");
  endtask
  task automatic t_map();
    acc(24'h000000, RD, 2'h0, 1'b1);
    chk("region", {28'h0, amag_pkg::RG_EXT}, {28'h0, res_region});
    chk("external", 32'h1, {31'h0, res_external});
    acc(24'h200000, WR, 2'h0, 1'b1);
    chk("external", 32'h1, {31'h0, res_external});
    acc(24'h20B000, RD, 2'h0, 1'b1);
    chk("region", {28'h0, amag_pkg::RG_XBUS}, {28'h0, res_region});
    chk("external", 32'h0, {31'h0, res_external});
    acc(24'h00D800, RD, 2'h0, 1'b1);
    chk("region", {28'h0, amag_pkg::RG_DATA_SRAM}, {28'h0, res_region});
    chk("page", 32'h3, {22'h0, res_page});
    acc(24'h01D800, RD, 2'h0, 1'b1);
    chk("region", {28'h0, amag_pkg::RG_EXT}, {28'h0, res_region});
    acc(24'h00FE10, RD, 2'h0, 1'b1);
    chk("region", {28'h0, amag_pkg::RG_SFR}, {28'h0, res_region});
    acc(24'hE00010, WR, 2'h0, 1'b1);
    chk("page", 32'h380, {22'h0, res_page});
    $display("map done");
  endtask
  task automatic t_flash();
    acc(24'hC0F000, FE, 2'h0, 1'b0);
    acc(24'hC0FFFE, RD, 2'h0, 1'b0);
    acc(24'hC00180, RD, 2'h0, 1'b1);
    chk("flash_block", 32'h3, {22'h0, res_flash_block});
    wr(8'h18, 32'h1);
    acc(24'hC00010, WR, 2'h0, 1'b0);
    acc(24'hC01010, WR, 2'h0, 1'b1);
    wr(8'h00, 32'h10);
    acc(24'hC01000, RD, 2'h0, 1'b0);
    acc(24'hC01000, FE, 2'h0, 1'b1);
    wr(8'h20, 32'h0);
    acc(24'hC01000, RD, 2'h0, 1'b1);
    wr(8'h00, 32'h30);
    acc(24'hC01000, RD, 2'h0, 1'b0);
    wr(8'h00, 32'h0);
    $display("flash done");
  endtask
  task automatic t_program_sram();
    wr(8'h14, 32'h100);
    wr(8'h00, 32'h08);
    acc(24'hE000FE, WR, 2'h0, 1'b0);
    acc(24'hE00100, WR, 2'h0, 1'b1);
    acc(24'hE00010, RD, 2'h0, 1'b1);
    wr(8'h00, 32'h0);
    $display("program sram done");
  endtask
  task automatic t_bits();
    acc(24'h00FD00, BI, 2'h0, 1'b1);
    acc(24'h00F600, BI, 2'h0, 1'b0);
    acc(24'hE00010, BI, 2'h0, 1'b0);
    acc(24'h00F000, BI, 2'h0, 1'b1);
    acc(24'h00FE00, BI, 2'h0, 1'b1);
    acc(24'h123456, GP, 2'h0, 1'b1);
    chk("gpr_addr", 32'hF606, {8'h0, res_addr});
    acc(24'h123456, GP | BY | BI, 2'h0, 1'b1);
    chk("gpr_addr", 32'hF603, {8'h0, res_addr});
    acc(24'h00D801, BY, 2'h0, 1'b1);
    chk("byte_en", 32'h2, {30'h0, res_byte_en});
    acc(24'h00D801, WR, 2'h0, 1'b1);
    chk("byte_en", 32'h3, {30'h0, res_byte_en});
    $display("bit access done");
  endtask
  task automatic t_stack();
    acc(24'h00F5FE, ST | WR, 2'h0, 1'b0);
    chk("stack_over", 32'h1, {31'h0, trap_stack_over});
    acc(24'h00FE00, ST, 2'h0, 1'b0);
    chk("stack_under", 32'h1, {31'h0, trap_stack_under});
    acc(24'h00F600, ST | WR, 2'h0, 1'b1);
    chk("stack_over", 32'h0, {31'h0, trap_stack_over});
    $display("stack done");
  endtask
  task automatic t_prot();
    wr(8'h40, 32'h0);
    wr(8'h44, 32'hFFFFFF);
    wr(8'h48, 32'h1);
    wr(8'h00, 32'h1);
    acc(24'h00D800, RD, 2'h0, 1'b1);
    chk("trap_prot", 32'h0, {31'h0, trap_prot});
    acc(24'h00D800, WR, 2'h0, 1'b0);
    chk("trap_prot", 32'h1, {31'h0, trap_prot});
    acc(24'h00D800, FE, 2'h0, 1'b0);
    acc(24'h00D800, RD, 2'h1, 1'b0);
    wr(8'h48, 32'h7);
    acc(24'h00D800, WR, 2'h0, 1'b1);
    rdc("stat", 8'h04, 32'h0000000F);
    wr(8'h04, 32'h0000003F);
    rdc("stat", 8'h04, 32'h0);
    wr(8'h00, 32'h0);
    $display("protection done");
  endtask
  task automatic t_mem();
    wr(8'h00, 32'h4);
    CPU.mem(21'h000004);
    #1;
    chk("corrected", 32'h1, {31'h0, rd_corrected});
    chk("rd_data", 32'h0, {16'h0, rd_data});
    chk("rd_valid", 32'h1, {31'h0, rd_valid});
    CPU.mem(21'h100002);
    #1;
    chk("rd_error", 32'h1, {31'h0, rd_error});
    wr(8'h00, 32'h2);
    CPU.mem(21'h000001);
    #1;
    chk("rd_error", 32'h1, {31'h0, rd_error});
    chk("rd_valid", 32'h0, {31'h0, rd_valid});
    CPU.mem(21'h000005);
    #1;
    chk("rd_data", 32'h1, {16'h0, rd_data});
    $display("memory check done");
  endtask
  task automatic t_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("ctrl", 8'h00, 32'h0);
    rdc("stat", 8'h04, 32'h0);
    $display("reset done");
  endtask
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_map();
    t_flash();
    t_program_sram();
    t_bits();
    t_stack();
    t_prot();
    t_mem();
    t_reset();
    end_of_test();
  end
endmodule
